// file: hdl/fppel_top.sv
// Contract
// - Large package: four-bit port, three bidirectional pins
// - Analog-selected lower pin reads zero
// - Direction one floats pin, zero drives latch
// - Pull-up bit gates neighbour pull-ups by latch
// - Reset makes lower pins analog inputs
// - Latch register reads back latch, not pins
// - Fourth pin input-only, master clear input when configured
// - Fourth pin digital after reset only without clear
// - Small package: only fourth pin input bit
// - Fourth pin bit reads zero when clear configured
// - Small package: other bits and registers read zero
// - Unused data, latch, direction bits read zero
// - Driven output ignores analog selection
// - Parallel port enabled: driven pins carry clocks, enable; direction still from the register
// - Fourth pin never driven, always an input
// - High-voltage detect always available on fourth pin
`timescale 1ns/100ps
`default_nettype none
module fppel_top
    import fppel_pkg::*;
#(
    parameter bit LARGE_PKG = 1'b1,  // Four-bit port variant
    parameter int ADDR_W    = 4      // AXI address width used
) (
    input  wire logic              CLK_SYS,
    input  wire logic              RSTN,
    // AXI4-Lite slave
    input  wire logic [ADDR_W-1:0] AWADDR,
    input  wire logic              AWVALID,
    output var  logic              AWREADY,
    input  wire logic [31:0]       WDATA,
    input  wire logic [3:0]        WSTRB,
    input  wire logic              WVALID,
    output var  logic              WREADY,
    output var  logic [1:0]        BRESP,
    output var  logic              BVALID,
    input  wire logic              BREADY,
    input  wire logic [ADDR_W-1:0] ARADDR,
    input  wire logic              ARVALID,
    output var  logic              ARREADY,
    output var  logic [31:0]       RDATA,
    output var  logic [1:0]        RRESP,
    output var  logic              RVALID,
    input  wire logic              RREADY,
    // Lower pins, three signals each
    input  wire logic [2:0]        PIN_LOW_IN,
    output var  logic [2:0]        PIN_LOW_OUT,
    output var  logic [2:0]        PIN_LOW_OE_N,
    // Input-only pin and its high-voltage detector
    input  wire logic              INPUT_ONLY_PIN_IN,
    input  wire logic              HIGH_VOLTAGE_DETECT_IN,
    input  wire logic              MASTER_CLEAR_CONFIG_ENABLE,
    output var  logic              MASTER_CLEAR_REQUEST,
    output var  logic              PROGRAM_ENTRY_DETECT,
    // Streaming parallel port outputs
    input  wire logic              PARALLEL_PORT_ENABLE,
    input  wire logic              PARALLEL_CLOCK_ONE,
    input  wire logic              PARALLEL_CLOCK_TWO,
    input  wire logic              PARALLEL_OUTPUT_ENABLE,
    // Analog selection to the converter
    output var  logic [2:0]        ANALOG_SELECT,
    // Neighbour port pull-ups
    input  wire logic [7:0]        NEIGHBOUR_LATCH,
    output var  logic [7:0]        NEIGHBOUR_PULLUP_ON
);

    if (ADDR_W < 4 || ADDR_W > 32) begin : g_chk
        $error("fppel_top: ADDR_W must lie between 4 and 32");
    end

    // Word-aligned register index compare, used by read and write decode
    function automatic logic fppel_hit(input logic [ADDR_W-1:0] a,
                                       input logic [3:0]        ofs);
        logic upper_zero;
        upper_zero = (a >> 4) == '0;
        return upper_zero && (a[3:2] == ofs[3:2]);
    endfunction

    // Whole-register mapping check; small package maps only the data word
    function automatic logic fppel_mapped(input logic [ADDR_W-1:0] a);
        logic hit;
        hit = fppel_hit(a, FPPEL_OFS_DATA);
        if (LARGE_PKG) begin
            hit = hit || fppel_hit(a, FPPEL_OFS_LATCH) || fppel_hit(a, FPPEL_OFS_DIR)
                  || fppel_hit(a, FPPEL_OFS_ANSEL);
        end
        return hit;
    endfunction

    // Synchronised pin levels
    logic [4:0] pin_raw;              // All pin inputs, from outside the clock
    logic [4:0] pin_syn;              // After two flops
    logic [2:0] low_syn;              // Lower pins
    logic       only_syn;             // Input-only pin
    logic       hv_syn;               // High-voltage detector

    // The clear pin idles high, so it is carried inverted: the synchroniser's
    // cleared state then means an idle pin and no false clear after reset
    assign pin_raw = {HIGH_VOLTAGE_DETECT_IN, ~INPUT_ONLY_PIN_IN, PIN_LOW_IN};

    fppel_sync #(
        .W (5)
    ) u_sync (
        .clk   (CLK_SYS),
        .rst_n (RSTN),
        .d     (pin_raw),
        .q     (pin_syn)
    );

    assign low_syn  = pin_syn[2:0];
    assign only_syn = ~pin_syn[3];
    assign hv_syn   = pin_syn[4];

    // Port state
    logic [2:0] latch_q;              // Output latches
    logic [2:0] latch_d;
    logic [2:0] dir_q;                // One means input
    logic [2:0] dir_d;
    logic [2:0] ansel_q;              // One means analog
    logic [2:0] ansel_d;
    logic       pullup_q;             // Neighbour pull-up enable
    logic       pullup_d;
    logic       master_clear_input_cfg_q;           // Configuration strap, caught in reset
    logic       master_clear_input_cfg_d;

    // Bus state
    logic        aw_got_q;            // Write address held
    logic        aw_got_d;
    logic        w_got_q;             // Write data held
    logic        w_got_d;
    fppel_wreq_t wreq_q;              // Captured write request
    fppel_wreq_t wreq_d;
    logic        bvalid_q;
    logic        bvalid_d;
    logic [1:0]  bresp_q;
    logic [1:0]  bresp_d;
    logic        rvalid_q;
    logic        rvalid_d;
    logic [1:0]  rresp_q;
    logic [1:0]  rresp_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;

    logic        do_write;            // Both halves present, response free
    logic        wr_ok;               // Write targets a mapped word
    logic        lane0;               // Low byte strobed
    logic [7:0]  data_view;           // Data register as read
    logic [7:0]  rd_byte;             // Selected read value
    logic [ADDR_W-1:0] waddr;         // Held write address at bus width

    // Handshake outputs are combinational; a new write waits for the response
    assign AWREADY  = !aw_got_q && !bvalid_q;
    assign WREADY   = !w_got_q && !bvalid_q;
    assign ARREADY  = !rvalid_q;
    assign BVALID   = bvalid_q;
    assign BRESP    = bresp_q;
    assign RVALID   = rvalid_q;
    assign RRESP    = rresp_q;
    assign RDATA    = rdata_q;
    assign do_write = aw_got_q && w_got_q && !bvalid_q;
    assign waddr    = ADDR_W'(wreq_q.addr);
    // Aligned words never carry low bits, so the miss marker cannot alias a word
    assign wr_ok    = (wreq_q.addr[1:0] == 2'h0) && fppel_mapped(waddr);
    assign lane0    = wreq_q.strb[0];

    // Data register view; lower bits follow the pins, gated by analog select
    always_comb begin
        data_view = 8'h00;
        if (!master_clear_input_cfg_q) begin
            data_view[FPPEL_POS_INONLY] = only_syn;
        end
        if (LARGE_PKG) begin
            data_view[2:0] = low_syn & ~ansel_q;
            data_view[FPPEL_POS_PULLUP] = pullup_q;
        end
    end

    // Read decode; unused latch and direction bits stay zero
    always_comb begin
        rd_byte = 8'h00;
        if (fppel_hit(ARADDR, FPPEL_OFS_DATA)) begin
            rd_byte = data_view;
        end else if (LARGE_PKG && fppel_hit(ARADDR, FPPEL_OFS_LATCH)) begin
            rd_byte = {5'h00, latch_q};
        end else if (LARGE_PKG && fppel_hit(ARADDR, FPPEL_OFS_DIR)) begin
            rd_byte = {5'h00, dir_q};
        end else if (LARGE_PKG && fppel_hit(ARADDR, FPPEL_OFS_ANSEL)) begin
            rd_byte = {5'h00, ansel_q};
        end
    end

    // Bus channel next values
    always_comb begin
        aw_got_d = aw_got_q;
        w_got_d  = w_got_q;
        wreq_d   = wreq_q;
        bvalid_d = bvalid_q;
        bresp_d  = bresp_q;
        rvalid_d = rvalid_q;
        rresp_d  = rresp_q;
        rdata_d  = rdata_q;
        // Address and data may arrive in either order
        if (AWVALID && AWREADY) begin
            aw_got_d    = 1'b1;
            wreq_d.addr = {AWADDR[3:2], 2'h0};
            if ((AWADDR >> 4) != '0) begin
                wreq_d.addr = 4'hF;                             // Forces a miss
            end
        end
        if (WVALID && WREADY) begin
            w_got_d     = 1'b1;
            wreq_d.data = WDATA;
            wreq_d.strb = WSTRB;
        end
        if (do_write) begin
            aw_got_d = 1'b0;
            w_got_d  = 1'b0;
            bvalid_d = 1'b1;
            bresp_d  = wr_ok ? FPPEL_RESP_OKAY : FPPEL_RESP_SLVERR;
        end else if (bvalid_q && BREADY) begin
            bvalid_d = 1'b0;
        end
        // Reads answer one cycle after the address is taken
        if (ARVALID && ARREADY) begin
            rvalid_d = 1'b1;
            rdata_d  = {24'h000000, rd_byte};
            rresp_d  = fppel_mapped(ARADDR) ? FPPEL_RESP_OKAY : FPPEL_RESP_SLVERR;
        end else if (rvalid_q && RREADY) begin
            rvalid_d = 1'b0;
        end
    end

    // Port register next values; writes apply only with the low byte lane
    always_comb begin
        latch_d    = latch_q;
        dir_d      = dir_q;
        ansel_d    = ansel_q;
        pullup_d   = pullup_q;
        master_clear_input_cfg_d = master_clear_input_cfg_q;
        if (!RSTN) begin
            master_clear_input_cfg_d = MASTER_CLEAR_CONFIG_ENABLE;
        end
        if (do_write && wr_ok && lane0 && LARGE_PKG) begin
            if (fppel_hit(waddr, FPPEL_OFS_DATA)) begin
                latch_d  = wreq_q.data[2:0];
                pullup_d = wreq_q.data[FPPEL_POS_PULLUP];
            end else if (fppel_hit(waddr, FPPEL_OFS_LATCH)) begin
                latch_d = wreq_q.data[2:0];
            end else if (fppel_hit(waddr, FPPEL_OFS_DIR)) begin
                dir_d = wreq_q.data[2:0];
            end else if (fppel_hit(waddr, FPPEL_OFS_ANSEL)) begin
                ansel_d = wreq_q.data[2:0];
            end
        end
    end

    // Registers; the strap flop is loaded during reset, not cleared
    always_ff @(posedge CLK_SYS) begin
        master_clear_input_cfg_q <= master_clear_input_cfg_d;
        if (!RSTN) begin
            latch_q  <= FPPEL_RST_LATCH;
            dir_q    <= FPPEL_RST_DIR;
            ansel_q  <= FPPEL_RST_ANSEL;
            pullup_q <= FPPEL_RST_PULLUP;
            aw_got_q <= 1'b0;
            w_got_q  <= 1'b0;
            wreq_q   <= '0;
            bvalid_q <= 1'b0;
            bresp_q  <= FPPEL_RESP_OKAY;
            rvalid_q <= 1'b0;
            rresp_q  <= FPPEL_RESP_OKAY;
            rdata_q  <= 32'h00000000;
        end else begin
            latch_q  <= latch_d;
            dir_q    <= dir_d;
            ansel_q  <= ansel_d;
            pullup_q <= pullup_d;
            aw_got_q <= aw_got_d;
            w_got_q  <= w_got_d;
            wreq_q   <= wreq_d;
            bvalid_q <= bvalid_d;
            bresp_q  <= bresp_d;
            rvalid_q <= rvalid_d;
            rresp_q  <= rresp_d;
            rdata_q  <= rdata_d;
        end
    end

    // Pin drive; analog selection never touches the output path
    fppel_drive_t drv;                // Combined drive of the lower pins
    always_comb begin
        drv.out  = latch_q;
        if (PARALLEL_PORT_ENABLE) begin
            drv.out = {PARALLEL_OUTPUT_ENABLE, PARALLEL_CLOCK_TWO,
                       PARALLEL_CLOCK_ONE};
        end
        drv.oe_n = dir_q;
        if (!LARGE_PKG) begin
            drv = '{out: 3'h0, oe_n: 3'h7};
        end
    end

    assign PIN_LOW_OUT  = drv.out;
    assign PIN_LOW_OE_N = drv.oe_n;
    assign ANALOG_SELECT = LARGE_PKG ? ansel_q : 3'h0;

    // The input-only pin has no driver at all; it feeds clear or port data
    assign MASTER_CLEAR_REQUEST = master_clear_input_cfg_q && !only_syn;
    assign PROGRAM_ENTRY_DETECT = hv_syn;

    // Neighbour pull-ups follow that port's latches while enabled
    assign NEIGHBOUR_PULLUP_ON = (LARGE_PKG && pullup_q) ? NEIGHBOUR_LATCH
                                                         : 8'h00;

endmodule
`default_nettype wire

// file: hdl/fppel_pkg.sv
// Shared constants and carriers for the four-pin port block
package fppel_pkg;

    // Register byte addresses on the AXI4-Lite bus
    localparam logic [3:0] FPPEL_OFS_DATA   = 4'h0;  // Pin data and neighbour pull-up
    localparam logic [3:0] FPPEL_OFS_LATCH  = 4'h4;  // Output latch
    localparam logic [3:0] FPPEL_OFS_DIR    = 4'h8;  // Direction register
    localparam logic [3:0] FPPEL_OFS_ANSEL  = 4'hC;  // Analog select of the lower pins

    // Field positions in the data register
    localparam int FPPEL_POS_PULLUP = 7;              // Neighbour pull-up enable
    localparam int FPPEL_POS_INONLY = 3;              // Input-only pin

    // Widths
    localparam int FPPEL_LOW_W = 3;                   // Bidirectional lower pins
    localparam int FPPEL_NB_W  = 8;                   // Neighbour port width

    // Values after reset
    localparam logic [2:0] FPPEL_RST_LATCH  = 3'h0;   // Latches cleared
    localparam logic [2:0] FPPEL_RST_DIR    = 3'h7;   // All lower pins inputs
    localparam logic [2:0] FPPEL_RST_ANSEL  = 3'h7;   // All lower pins analog
    localparam logic       FPPEL_RST_PULLUP = 1'b0;   // Pull-ups off

    // AXI responses
    localparam logic [1:0] FPPEL_RESP_OKAY   = 2'h0;
    localparam logic [1:0] FPPEL_RESP_SLVERR = 2'h2;

    // Synchroniser depth for pin inputs
    localparam int FPPEL_SYNC_STAGES = 2;

    // Captured write request
    typedef struct packed {
        logic [3:0]  addr;   // Word-aligned byte address, or F to force a miss
        logic [31:0] data;   // Write data
        logic [3:0]  strb;   // Byte strobes
    } fppel_wreq_t;

    // Drive of the lower pins
    typedef struct packed {
        logic [2:0] out;     // Level driven
        logic [2:0] oe_n;    // Low while driven
    } fppel_drive_t;

endpackage

// file: hdl/fppel_sync.sv
`timescale 1ns/100ps
`default_nettype none
// Two-flop synchroniser for asynchronous pin levels
module fppel_sync
    import fppel_pkg::*;
#(
    parameter int W = 1  // Number of bits synchronised
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output var  logic [W-1:0] q
);

    logic [W-1:0] meta_q;  // First stage, read only by the second
    logic [W-1:0] meta_d;
    logic [W-1:0] stab_q;  // Second stage, safe to use
    logic [W-1:0] stab_d;

    if (W < 1) begin : g_chk
        $error("fppel_sync: width must be at least one");
    end

    // Next values: shift the pin level through
    always_comb begin
        meta_d = d;
        stab_d = meta_q;
    end

    // Register both stages
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta_q <= '0;
            stab_q <= '0;
        end else begin
            meta_q <= meta_d;
            stab_q <= stab_d;
        end
    end

    assign q = stab_q;

endmodule
`default_nettype wire

// file: bench/fppel_checker.sv
`timescale 1ns/100ps
`default_nettype none
// Watches pin drive, strap paths and bus answers at the top ports
module fppel_checker
    import fppel_pkg::*;
(
    input wire logic        CLK_SYS,
    input wire logic        RSTN,
    input wire logic        ARVALID,
    input wire logic        ARREADY,
    input wire logic        RVALID,
    input wire logic [31:0] RDATA,
    input wire logic        BVALID,
    input wire logic        BREADY,
    input wire logic [2:0]  PIN_LOW_OUT,
    input wire logic [2:0]  PIN_LOW_OE_N,
    input wire logic        INPUT_ONLY_PIN_IN,
    input wire logic        HIGH_VOLTAGE_DETECT_IN,
    input wire logic        MASTER_CLEAR_REQUEST,
    input wire logic        PROGRAM_ENTRY_DETECT,
    input wire logic        PARALLEL_PORT_ENABLE,
    input wire logic        PARALLEL_CLOCK_ONE,
    input wire logic        PARALLEL_CLOCK_TWO,
    input wire logic        PARALLEL_OUTPUT_ENABLE,
    input wire logic [2:0]  ANALOG_SELECT,
    input wire logic [7:0]  NEIGHBOUR_LATCH,
    input wire logic [7:0]  NEIGHBOUR_PULLUP_ON
);
    // One domain, so clock and reset are named once
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!RSTN);
    rst_state_a: assert property (!$past(RSTN) |-> {PIN_LOW_OE_N, ANALOG_SELECT} == 6'h3F)
        else $error("lower pins not analog inputs after reset");
    pullup_gate_a: assert property (NEIGHBOUR_PULLUP_ON == 8'h00 || NEIGHBOUR_PULLUP_ON == NEIGHBOUR_LATCH)
        else $error("pull-ups not gated by latch");
    dir_write_a: assert property ($changed(PIN_LOW_OE_N) |-> $rose(BVALID))
        else $error("drive enable moved without a write");
    // Outside parallel mode the driven level comes from the latches only
    out_write_a: assert property (!PARALLEL_PORT_ENABLE && !$past(PARALLEL_PORT_ENABLE) && $changed(PIN_LOW_OUT) |-> $rose(BVALID))
        else $error("pin level moved without a write");
    par_route_a: assert property (PARALLEL_PORT_ENABLE |-> PIN_LOW_OUT == {PARALLEL_OUTPUT_ENABLE, PARALLEL_CLOCK_TWO, PARALLEL_CLOCK_ONE})
        else $error("parallel outputs not routed");
    // Two synchroniser stages, so the cause lies two edges back
    clear_pin_a: assert property ($past(RSTN, 2) && MASTER_CLEAR_REQUEST |-> !$past(INPUT_ONLY_PIN_IN, 2))
        else $error("clear request without low pin");
    hv_detect_a: assert property ($past(RSTN, 2) |-> PROGRAM_ENTRY_DETECT == $past(HIGH_VOLTAGE_DETECT_IN, 2))
        else $error("high-voltage detect lost");
    one_resp_a: assert property (BVALID && BREADY |=> !BVALID)
        else $error("write answered twice");
    read_ans_a: assert property (ARVALID && ARREADY |=> RVALID)
        else $error("read answer late");
    read_zero_a: assert property (RVALID |-> RDATA[31:8] == 24'h0 && RDATA[6:4] == 3'h0)
        else $error("unimplemented bits not zero");
endmodule
bind fppel_top fppel_checker u_chk (.CLK_SYS, .RSTN, .ARVALID, .ARREADY, .RVALID, .RDATA,
    .BVALID, .BREADY, .PIN_LOW_OUT, .PIN_LOW_OE_N, .INPUT_ONLY_PIN_IN, .HIGH_VOLTAGE_DETECT_IN,
    .MASTER_CLEAR_REQUEST, .PROGRAM_ENTRY_DETECT, .PARALLEL_PORT_ENABLE, .PARALLEL_CLOCK_ONE,
    .PARALLEL_CLOCK_TWO, .PARALLEL_OUTPUT_ENABLE, .ANALOG_SELECT, .NEIGHBOUR_LATCH,
    .NEIGHBOUR_PULLUP_ON);
`default_nettype wire

// file: bench/fppel_board.sv
`timescale 1ns/100ps
`default_nettype none
// Board side of the three lower pins
module fppel_board
    import fppel_pkg::*;
(
    input  wire logic [2:0] PIN_LOW_OUT,
    input  wire logic [2:0] PIN_LOW_OE_N,
    input  wire logic [2:0] ext_level,
    output wire logic [2:0] PIN_LOW_IN
);
    // A driven wire shows the block's level, a floating one the board's own drive
    assign PIN_LOW_IN = (PIN_LOW_OE_N & ext_level) | (~PIN_LOW_OE_N & PIN_LOW_OUT);
endmodule
`default_nettype wire

// file: bench/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top
    import fppel_pkg::*;
;
    logic        CLK_SYS = 1'b0, RSTN = 1'b0;
    logic [7:0]  AWADDR = 8'h00, ARADDR = 8'h00, NEIGHBOUR_LATCH = 8'h00;
    logic [31:0] WDATA = 32'h0, ev;
    logic [3:0]  WSTRB = 4'hF;
    logic        AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0, ARVALID = 1'b0, RREADY = 1'b0;
    logic        INPUT_ONLY_PIN_IN = 1'b1, HIGH_VOLTAGE_DETECT_IN = 1'b0;
    logic        MASTER_CLEAR_CONFIG_ENABLE = 1'b0, PARALLEL_PORT_ENABLE = 1'b0;
    logic        PARALLEL_CLOCK_ONE = 1'b0, PARALLEL_CLOCK_TWO = 1'b0, PARALLEL_OUTPUT_ENABLE = 1'b0;
    logic [2:0]  ext_level = 3'h0, lat = 3'h0, dir, an;
    logic        pu = 1'b0;
    int          bad_count = 0, samples_checked = 0;
    wire logic        AWREADY, WREADY, BVALID, ARREADY, RVALID;
    wire logic        MASTER_CLEAR_REQUEST, PROGRAM_ENTRY_DETECT;
    wire logic [1:0]  BRESP, RRESP;
    wire logic [31:0] RDATA;
    wire logic [2:0]  PIN_LOW_IN, PIN_LOW_OUT, PIN_LOW_OE_N, ANALOG_SELECT;
    wire logic [7:0]  NEIGHBOUR_PULLUP_ON;

    // 40 MHz system clock
    always #12.5 CLK_SYS = ~CLK_SYS;

    fppel_top #(.LARGE_PKG(1'b1), .ADDR_W(8)) dut (.CLK_SYS, .RSTN, .AWADDR, .AWVALID, .AWREADY,
        .WDATA, .WSTRB, .WVALID, .WREADY, .BRESP, .BVALID, .BREADY, .ARADDR, .ARVALID, .ARREADY,
        .RDATA, .RRESP, .RVALID, .RREADY, .PIN_LOW_IN, .PIN_LOW_OUT, .PIN_LOW_OE_N,
        .INPUT_ONLY_PIN_IN, .HIGH_VOLTAGE_DETECT_IN, .MASTER_CLEAR_CONFIG_ENABLE,
        .MASTER_CLEAR_REQUEST, .PROGRAM_ENTRY_DETECT, .PARALLEL_PORT_ENABLE, .PARALLEL_CLOCK_ONE,
        .PARALLEL_CLOCK_TWO, .PARALLEL_OUTPUT_ENABLE, .ANALOG_SELECT, .NEIGHBOUR_LATCH,
        .NEIGHBOUR_PULLUP_ON);
    fppel_board board (.PIN_LOW_OUT, .PIN_LOW_OE_N, .ext_level, .PIN_LOW_IN);

    // Data register image: pull-up, input-only pin unless strapped, digital pins only
    function automatic logic [31:0] exp_dat(logic p, logic i3, logic s, logic [2:0] w, logic [2:0] a);
        return {24'h0, p, 3'h0, i3 & ~s, w & ~a};
    endfunction
    // Wire level: board drive where floating, latch where driven
    function automatic logic [2:0] exp_pin(logic [2:0] d, logic [2:0] l, logic [2:0] x);
        return (d & x) | (~d & l);
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic complete_run;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic hang;
        bad_count++;
        $display("[FAIL] %0t bus answer missing", $time);
        complete_run();
    endtask

    // Handshakes are judged mid-cycle, so the decision matches what the edge samples
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic ta, tw, tv;
        logic [1:0] r;
        @(posedge CLK_SYS);
        AWADDR <= a;
        WDATA <= d;
        AWVALID <= 1'b1;
        WVALID <= 1'b1;
        BREADY <= 1'b1;
        for (int n = 0; n < 20; n++) begin
            @(negedge CLK_SYS);
            ta = AWVALID & AWREADY;
            tw = WVALID & WREADY;
            tv = BVALID;
            r = BRESP;
            @(posedge CLK_SYS);
            if (ta) AWVALID <= 1'b0;
            if (tw) WVALID <= 1'b0;
            if (tv) begin
                BREADY <= 1'b0;
                chk(32'(r), 32'(er));
                return;
            end
        end
        hang();
    endtask

    task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        logic ta, tv;
        logic [31:0] d;
        logic [1:0] r;
        @(posedge CLK_SYS);
        ARADDR <= a;
        ARVALID <= 1'b1;
        RREADY <= 1'b1;
        for (int n = 0; n < 20; n++) begin
            @(negedge CLK_SYS);
            ta = ARVALID & ARREADY;
            tv = RVALID;
            d = RDATA;
            r = RRESP;
            @(posedge CLK_SYS);
            if (ta) ARVALID <= 1'b0;
            if (tv) begin
                RREADY <= 1'b0;
                chk(d, e);
                chk(32'(r), 32'(er));
                return;
            end
        end
        hang();
    endtask

    initial begin
        void'($urandom(32'h389E));
        repeat (8) @(posedge CLK_SYS);
        RSTN <= 1'b1;
        rc(8'h08, 32'h7, 2'h0);
        rc(8'h0C, 32'h7, 2'h0);
        rc(8'h04, 32'h0, 2'h0);
        rc(8'h00, 32'h8, 2'h0);
        for (int i = 0; i < 10; i++) begin
            an = 3'($urandom);
            // First pass drives analog pins on purpose; later passes keep them inputs
            dir = (i == 0) ? 3'h0 : 3'($urandom) | an;
            lat = 3'($urandom);
            wr(8'h0C, {29'($urandom), an}, 2'h0);
            wr(8'h08, {29'($urandom), dir}, 2'h0);
            if (i[0]) begin
                pu = 1'($urandom);
                wr(8'h00, {24'($urandom), pu, 4'($urandom), lat}, 2'h0);
            end else begin
                wr(8'h04, {29'($urandom), lat}, 2'h0);
            end
            ext_level <= 3'($urandom);
            INPUT_ONLY_PIN_IN <= 1'($urandom);
            HIGH_VOLTAGE_DETECT_IN <= 1'($urandom);
            NEIGHBOUR_LATCH <= 8'($urandom);
            repeat (3) @(posedge CLK_SYS);
            @(negedge CLK_SYS);
            chk(32'(PIN_LOW_OE_N), 32'(dir));
            chk(32'(PIN_LOW_OUT), 32'(lat));
            chk(32'(NEIGHBOUR_PULLUP_ON), pu ? 32'(NEIGHBOUR_LATCH) : 32'h0);
            chk(32'(ANALOG_SELECT), 32'(an));
            chk(32'(PROGRAM_ENTRY_DETECT), 32'(HIGH_VOLTAGE_DETECT_IN));
            chk(32'(MASTER_CLEAR_REQUEST), 32'h0);
            rc(8'h04, 32'(lat), 2'h0);
            ev = exp_dat(pu, INPUT_ONLY_PIN_IN, 1'b0, exp_pin(dir, lat, ext_level), an);
            rc(8'h00, ev, 2'h0);
        end
        PARALLEL_PORT_ENABLE <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            {PARALLEL_OUTPUT_ENABLE, PARALLEL_CLOCK_TWO, PARALLEL_CLOCK_ONE} <= 3'($urandom);
            @(negedge CLK_SYS);
            ev = 32'({PARALLEL_OUTPUT_ENABLE, PARALLEL_CLOCK_TWO, PARALLEL_CLOCK_ONE});
            chk(32'(PIN_LOW_OUT), ev);
            @(posedge CLK_SYS);
        end
        PARALLEL_PORT_ENABLE <= 1'b0;
        // Unmapped place: error answer, zero data, nothing disturbed
        wr(8'h10, $urandom, 2'h2);
        rc(8'h10, 32'h0, 2'h2);
        rc(8'h0C, 32'(an), 2'h0);
        // Low byte lane off: the write is answered but changes nothing
        WSTRB <= 4'hE;
        wr(8'h04, {29'h0, ~lat}, 2'h0);
        WSTRB <= 4'hF;
        rc(8'h04, 32'(lat), 2'h0);
        // Second reset with the clear strap set
        @(posedge CLK_SYS);
        RSTN <= 1'b0;
        MASTER_CLEAR_CONFIG_ENABLE <= 1'b1;
        INPUT_ONLY_PIN_IN <= 1'b1;
        repeat (8) @(posedge CLK_SYS);
        RSTN <= 1'b1;
        rc(8'h08, 32'h7, 2'h0);
        rc(8'h00, 32'h0, 2'h0);
        chk(32'(MASTER_CLEAR_REQUEST), 32'h0);
        INPUT_ONLY_PIN_IN <= 1'b0;
        HIGH_VOLTAGE_DETECT_IN <= 1'b1;
        repeat (3) @(posedge CLK_SYS);
        @(negedge CLK_SYS);
        chk(32'(MASTER_CLEAR_REQUEST), 32'h1);
        chk(32'(PROGRAM_ENTRY_DETECT), 32'h1);
        complete_run();
    end
endmodule
`default_nettype wire
